// ==== hw/shcc_pkg.sv ====
// shared constants for the sample-hold channel control link
// assumes a 40 mhz core clock at both ends
package shcc_pkg;
	// ==========================================
	// timing
	localparam int CORE_PERIOD_PS = 25000;
	localparam int ACQ_TIME_NS = 16000;
	localparam int ACQ_CYC = ACQ_TIME_NS * 1000 / CORE_PERIOD_PS;
	localparam int RST_MIN_NS = 50;
	localparam int RST_MIN_CYC = (RST_MIN_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
	localparam int RST_MAX_NS = 150;
	localparam int RST_MAX_CYC = RST_MAX_NS * 1000 / CORE_PERIOD_PS;
	localparam int SCLK_HALF_NS = 200;
	localparam int SCLK_HALF_CYC = SCLK_HALF_NS * 1000 / CORE_PERIOD_PS;
	localparam int RST_PULSE_NS = 100;
	localparam int RST_PULSE_CYC = RST_PULSE_NS * 1000 / CORE_PERIOD_PS;
	// ==========================================
	// serial word layout, msb first
	localparam int HDR_BITS = 10;
	localparam int CODE_BITS = 14;
	localparam int WORD_BITS = 24;
	localparam int HDR_MODE_HI = 9;
	localparam int HDR_MODE_LO = 8;
	localparam int HDR_CAL = 7;
	localparam int HDR_OFFS = 6;
	localparam int HDR_ADDR_HI = 5;
	localparam int CH_NUM = 64;
	localparam int OFFS_IDX = 64;
	typedef enum logic [1:0] {
		MODE_SHA = 2'h0,
		MODE_DAC = 2'h1,
		MODE_ACQ_RB = 2'h2,
		MODE_RB = 2'h3
	} shcc_mode_t;
	// ==========================================
	// host register map
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_DATA = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam logic [7:0] REG_RB = 8'h10;
	localparam logic [7:0] REG_RBGO = 8'h14;
	localparam int CTRL_TRACK = 0;
	localparam int CTRL_SER = 1;
	localparam int CTRL_RST = 2;
	localparam logic [1:0] CTRL_RST_VAL = 2'h3;
	localparam int STAT_ACTIVE = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_RBV = 2;
endpackage : shcc_pkg

// ==== hw/shcc_if.sv ====
// pin bundle between the sample-hold device and its host
// assumes both ends sample every pin with their own core clock
`timescale 1ns/1ps
interface shcc_if;
	logic port_select;
	logic cs_sync_n;
	logic wr_n;
	logic [5:0] channel_address;
	logic offset_sel;
	logic cal;
	logic sclk;
	logic sdin;
	logic sdout;
	logic busy_n;
	logic track_rst_n;
	modport dev (input port_select, cs_sync_n, wr_n, channel_address, offset_sel, cal, sclk,
		sdin, track_rst_n, output sdout, busy_n);
	modport host (output port_select, cs_sync_n, wr_n, channel_address, offset_sel, cal, sclk,
		sdin, track_rst_n, input sdout, busy_n);
endinterface : shcc_if

// ==== hw/shcc_dev.sv ====
// device end: serial and parallel decode, acquisition sequencing, dac registers
// assumes every link pin is asynchronous to CORE_CLK; ADC_CODE is the converter result
`timescale 1ns/1ps
// Operation
// - parallel capture on write strobe rising edge
// - addressed with track high starts acquisition, busy
// - acquisition ends within 16 us, dac retakes
// - route sampled input during acquisition
// - power-on clears all dac registers
// - track low defers acquisition until rising
// - 50-150 ns low pulse resets device
// - pulse under 50 ns ignored
// - low over 150 ns acts as track
// - host selects serial or parallel port
// - two mode bits lead serial word
// - calibrate acquires all 64 channels
// - offset select overrides channel address
// - six-bit address, msb first
// - sample-hold command is ten bits
// - dac write adds 14-bit code
// - acquire-readback shifts after acquisition
// - readback-only shifts at next sync fall
// - readback data changes on rising sclk
// - one pin is chip select and sync
// - offset channel drives offset output
// - host data valid at falling sclk
// - host sclk at most 20 mhz
module shcc_dev (
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	shcc_if.dev LINK,
	input wire logic [13:0] ADC_CODE,
	input wire logic [6:0] DAC_RD_ADDR,
	output logic [13:0] DAC_RD_DATA,
	output logic [64:0] ROUTE_VIN,
	output logic [13:0] OFFSET_CHANNEL_OUTPUT
);
	// ==========================================
	// pin synchronisers
	logic [13:0] pin_raw;
	logic [13:0] s1_ff;
	logic [13:0] s2_ff;
	logic [13:0] s3_ff;
	assign pin_raw = {LINK.port_select, LINK.cs_sync_n, LINK.wr_n, LINK.offset_sel, LINK.cal,
		LINK.sclk, LINK.sdin, LINK.track_rst_n, LINK.channel_address};
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s1_ff <= 14'h3fff;
			s2_ff <= 14'h3fff;
			s3_ff <= 14'h3fff;
		end else begin
			s1_ff <= pin_raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
	logic ser, cs_n, trk, din;
	logic sck_fall, sck_rise, cs_fall, wr_rise, trk_rise;
	assign ser = s2_ff[13];
	assign cs_n = s2_ff[12];
	assign din = s2_ff[7];
	assign trk = s2_ff[6];
	assign sck_fall = s3_ff[8] & ~s2_ff[8];
	assign sck_rise = ~s3_ff[8] & s2_ff[8];
	assign cs_fall = s3_ff[12] & ~s2_ff[12];
	assign wr_rise = ~s3_ff[11] & s2_ff[11];
	assign trk_rise = ~s3_ff[6] & s2_ff[6];
	// ==========================================
	// track/reset pulse width filter
	logic [3:0] low_cnt_ff;
	logic soft_rst;
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			low_cnt_ff <= 4'h0;
		end else if (trk) begin
			low_cnt_ff <= 4'h0;
		end else if (low_cnt_ff <= 4'(shcc_pkg::RST_MAX_CYC)) begin
			low_cnt_ff <= low_cnt_ff + 4'h1;
		end
	end
	// counter saturates one above the window so long lows never look like resets
	assign soft_rst = trk_rise && (low_cnt_ff >= 4'(shcc_pkg::RST_MIN_CYC))
		&& (low_cnt_ff <= 4'(shcc_pkg::RST_MAX_CYC));
	// ==========================================
	// serial input shifter
	logic [4:0] bit_cnt_ff;
	logic [22:0] sh_ff;
	logic [9:0] hdr_ff;
	logic [9:0] hdr_now;
	logic rd_frame_ff;
	logic sbit, ser_hdr, ser_dat;
	assign sbit = sck_fall & ser & ~cs_n & ~rd_frame_ff;
	assign hdr_now = {sh_ff[8:0], din};
	assign ser_hdr = sbit && (bit_cnt_ff == 5'(shcc_pkg::HDR_BITS - 1));
	assign ser_dat = sbit && (bit_cnt_ff == 5'(shcc_pkg::WORD_BITS - 1))
		&& (hdr_ff[9:8] == shcc_pkg::MODE_DAC);
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			bit_cnt_ff <= 5'h00;
			sh_ff <= 23'h000000;
			hdr_ff <= 10'h000;
		end else if (soft_rst || cs_n) begin
			bit_cnt_ff <= 5'h00;
		end else if (sbit) begin
			sh_ff <= {sh_ff[21:0], din};
			if (bit_cnt_ff != 5'(shcc_pkg::WORD_BITS))
				bit_cnt_ff <= bit_cnt_ff + 5'h01;
			if (ser_hdr)
				hdr_ff <= hdr_now;
		end
	end
	// ==========================================
	// command decode, serial or parallel
	shcc_pkg::shcc_mode_t hmode;
	logic acq_go, go_all;
	logic [6:0] go_idx;
	logic [6:0] rb_idx_now;
	assign hmode = shcc_pkg::shcc_mode_t'(hdr_now[9:8]);
	always_comb begin
		acq_go = 1'b0;
		go_all = 1'b0;
		go_idx = 7'h00;
		if (ser && ser_hdr) begin
			acq_go = (hmode == shcc_pkg::MODE_SHA) || (hmode == shcc_pkg::MODE_ACQ_RB);
			go_all = hdr_now[shcc_pkg::HDR_CAL];
			go_idx = hdr_now[shcc_pkg::HDR_OFFS] ? 7'(shcc_pkg::OFFS_IDX)
				: {1'b0, hdr_now[5:0]};
		end else if (!ser && !cs_n && wr_rise) begin
			acq_go = 1'b1;
			go_all = s2_ff[9];
			go_idx = s2_ff[10] ? 7'(shcc_pkg::OFFS_IDX) : {1'b0, s2_ff[5:0]};
		end
	end
	assign rb_idx_now = hdr_now[shcc_pkg::HDR_OFFS] ? 7'(shcc_pkg::OFFS_IDX)
		: {1'b0, hdr_now[5:0]};
	// ==========================================
	// acquisition sequencer
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TRK = 3'b010,
		ST_ACQ = 3'b100
	} shcc_state_t;
	shcc_state_t state_ff;
	logic [9:0] acq_cnt_ff;
	logic tgt_all_ff;
	logic [6:0] tgt_idx_ff;
	logic busy_n_ff;
	logic [64:0] route_ff;
	logic acq_done;
	assign acq_done = (state_ff == ST_ACQ) && (acq_cnt_ff == 10'(shcc_pkg::ACQ_CYC - 1));
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_ff <= ST_IDLE;
			acq_cnt_ff <= 10'h000;
			tgt_all_ff <= 1'b0;
			tgt_idx_ff <= 7'h00;
			busy_n_ff <= 1'b1;
			route_ff <= '0;
		end else if (soft_rst) begin
			state_ff <= ST_IDLE;
			busy_n_ff <= 1'b1;
			route_ff <= '0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					// new addressing while busy is dropped; the host must wait
					if (acq_go) begin
						tgt_all_ff <= go_all;
						tgt_idx_ff <= go_idx;
						route_ff <= go_all ? {1'b0, {64{1'b1}}} : (65'h1 << go_idx);
						acq_cnt_ff <= 10'h000;
						if (trk) begin
							state_ff <= ST_ACQ;
							busy_n_ff <= 1'b0;
						end else begin
							state_ff <= ST_TRK;
						end
					end
				end
				ST_TRK: begin
					if (trk_rise) begin
						state_ff <= ST_ACQ;
						busy_n_ff <= 1'b0;
					end
				end
				ST_ACQ: begin
					if (acq_done) begin
						state_ff <= ST_IDLE;
						busy_n_ff <= 1'b1;
						route_ff <= '0;
					end else begin
						acq_cnt_ff <= acq_cnt_ff + 10'h001;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
					busy_n_ff <= 1'b1;
					route_ff <= '0;
				end
			endcase
		end
	end
	// ==========================================
	// dac registers, index 64 is the offset channel
	logic [13:0] dac_mem_ff [0:64];
	logic dac_all;
	logic [6:0] dac_idx;
	assign dac_all = hdr_ff[shcc_pkg::HDR_CAL];
	assign dac_idx = hdr_ff[shcc_pkg::HDR_OFFS] ? 7'(shcc_pkg::OFFS_IDX) : {1'b0, hdr_ff[5:0]};
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i <= shcc_pkg::OFFS_IDX; i++)
				dac_mem_ff[i] <= 14'h0000;
		end else begin
			for (int i = 0; i <= shcc_pkg::OFFS_IDX; i++) begin
				if (soft_rst)
					dac_mem_ff[i] <= 14'h0000;
				else if (acq_done && (tgt_all_ff ? (i < shcc_pkg::CH_NUM) : (i == tgt_idx_ff)))
					dac_mem_ff[i] <= ADC_CODE;
				else if (ser_dat && (dac_all ? (i < shcc_pkg::CH_NUM) : (i == dac_idx)))
					dac_mem_ff[i] <= {sh_ff[12:0], din};
			end
		end
	end
	// ==========================================
	// readback shifter
	logic rb_pend_ff;
	logic [6:0] rb_idx_ff;
	logic [13:0] so_ff;
	logic [3:0] so_cnt_ff;
	logic sdout_ff;
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rb_pend_ff <= 1'b0;
			rb_idx_ff <= 7'h00;
			so_ff <= 14'h0000;
			so_cnt_ff <= 4'h0;
			sdout_ff <= 1'b0;
			rd_frame_ff <= 1'b0;
		end else if (soft_rst) begin
			rb_pend_ff <= 1'b0;
			rd_frame_ff <= 1'b0;
			sdout_ff <= 1'b0;
		end else if (cs_n) begin
			rd_frame_ff <= 1'b0;
			sdout_ff <= 1'b0;
			if (ser_hdr) begin
				rb_pend_ff <= 1'b0;
			end
		end else if (cs_fall && ser && rb_pend_ff) begin
			// a frame during acquisition is swallowed and shifts zeros
			rd_frame_ff <= 1'b1;
			so_cnt_ff <= 4'(shcc_pkg::CODE_BITS - 1);
			if (state_ff == ST_IDLE) begin
				rb_pend_ff <= 1'b0;
				so_ff <= dac_mem_ff[rb_idx_ff];
				sdout_ff <= dac_mem_ff[rb_idx_ff][13];
			end else begin
				so_ff <= 14'h0000;
				sdout_ff <= 1'b0;
			end
		end else if (sck_rise && rd_frame_ff && (so_cnt_ff != 4'h0)) begin
			so_ff <= {so_ff[12:0], 1'b0};
			sdout_ff <= so_ff[12];
			so_cnt_ff <= so_cnt_ff - 4'h1;
		end else if (ser_hdr) begin
			rb_pend_ff <= (hmode == shcc_pkg::MODE_RB) || (hmode == shcc_pkg::MODE_ACQ_RB);
			rb_idx_ff <= rb_idx_now;
		end
	end
	// ==========================================
	// outputs
	logic [13:0] rd_data_ff;
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N)
			rd_data_ff <= 14'h0000;
		else if (DAC_RD_ADDR <= 7'(shcc_pkg::OFFS_IDX))
			rd_data_ff <= dac_mem_ff[DAC_RD_ADDR];
		else
			rd_data_ff <= 14'h0000;
	end
	assign DAC_RD_DATA = rd_data_ff;
	assign ROUTE_VIN = route_ff;
	assign OFFSET_CHANNEL_OUTPUT = dac_mem_ff[shcc_pkg::OFFS_IDX];
	assign LINK.busy_n = busy_n_ff;
	assign LINK.sdout = sdout_ff;
endmodule : shcc_dev

// ==== hw/shcc_host.sv ====
// host end: register port drives serial frames, parallel strobes and reset pulses
// assumes a 40 mhz core clock; sclk is divided down from it
`timescale 1ns/1ps
module shcc_host (
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	shcc_if.host LINK,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA
);
	// ==========================================
	// input synchronisers
	logic [1:0] s1_ff;
	logic [1:0] s2_ff;
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s1_ff <= 2'h1;
			s2_ff <= 2'h1;
		end else begin
			s1_ff <= {LINK.sdout, LINK.busy_n};
			s2_ff <= s1_ff;
		end
	end
	// ==========================================
	// frame engine
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_WAIT = 5'b00010,
		H_SER = 5'b00100,
		H_PAR = 5'b01000,
		H_GAP = 5'b10000
	} shcc_hstate_t;
	shcc_hstate_t st_ff;
	logic [13:0] data_ff;
	logic [1:0] ctrl_ff;
	logic [23:0] word_ff;
	logic [4:0] nbits_ff, cnt_ff;
	logic rd_ff, rbv_ff;
	logic [13:0] rb_ff;
	logic [3:0] div_ff;
	logic tick;
	logic sclk_ff, cs_n_ff, wr_n_ff, sdin_ff;
	logic launch, wr_cmd;
	assign tick = div_ff == 4'(shcc_pkg::SCLK_HALF_CYC - 1);
	assign wr_cmd = REG_WR && (REG_ADDR == shcc_pkg::REG_CMD);
	assign launch = (st_ff == H_IDLE) && REG_WR
		&& ((REG_ADDR == shcc_pkg::REG_CMD) || (REG_ADDR == shcc_pkg::REG_RBGO));
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_ff <= H_IDLE;
			word_ff <= 24'h000000;
			nbits_ff <= 5'h00;
			cnt_ff <= 5'h00;
			rd_ff <= 1'b0;
			rbv_ff <= 1'b0;
			rb_ff <= 14'h0000;
			div_ff <= 4'h0;
			sclk_ff <= 1'b1;
			cs_n_ff <= 1'b1;
			wr_n_ff <= 1'b1;
			sdin_ff <= 1'b0;
		end else begin
			div_ff <= (tick || st_ff == H_IDLE || st_ff == H_WAIT) ? 4'h0 : div_ff + 4'h1;
			unique case (st_ff)
				H_IDLE: begin
					if (launch) begin
						st_ff <= H_WAIT;
						rd_ff <= !wr_cmd;
						rbv_ff <= 1'b0;
						cnt_ff <= 5'h00;
						word_ff <= wr_cmd ? {REG_WDATA[9:0], data_ff} : 24'h000000;
						nbits_ff <= !wr_cmd ? 5'(shcc_pkg::CODE_BITS)
							: (REG_WDATA[9:8] == shcc_pkg::MODE_DAC) ? 5'(shcc_pkg::WORD_BITS)
							: 5'(shcc_pkg::HDR_BITS);
					end
				end
				H_WAIT: begin
					if (s2_ff[0]) begin
						cs_n_ff <= 1'b0;
						if (ctrl_ff[shcc_pkg::CTRL_SER]) begin
							st_ff <= H_SER;
							sdin_ff <= word_ff[23];
						end else begin
							st_ff <= H_PAR;
							wr_n_ff <= 1'b0;
						end
					end
				end
				H_SER: begin
					if (tick) begin
						if (sclk_ff) begin
							sclk_ff <= 1'b0;
							cnt_ff <= cnt_ff + 5'h01;
							rb_ff <= {rb_ff[12:0], s2_ff[1]};
						end else begin
							sclk_ff <= 1'b1;
							if (cnt_ff == nbits_ff) begin
								st_ff <= H_GAP;
								cs_n_ff <= 1'b1;
								rbv_ff <= rd_ff;
							end else begin
								word_ff <= {word_ff[22:0], 1'b0};
								sdin_ff <= word_ff[22];
							end
						end
					end
				end
				H_PAR: begin
					if (tick) begin
						if (!wr_n_ff) begin
							wr_n_ff <= 1'b1;
						end else begin
							cs_n_ff <= 1'b1;
							st_ff <= H_GAP;
						end
					end
				end
				H_GAP: begin
					// lets the device busy reach our synchroniser before the next wait
					if (tick)
						st_ff <= H_IDLE;
				end
				default: begin
					st_ff <= H_IDLE;
					cs_n_ff <= 1'b1;
					wr_n_ff <= 1'b1;
					sclk_ff <= 1'b1;
				end
			endcase
		end
	end
	// ==========================================
	// control registers and reset pulse
	logic [2:0] rstp_ff;
	logic track_ff;
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			data_ff <= 14'h0000;
			ctrl_ff <= shcc_pkg::CTRL_RST_VAL;
			rstp_ff <= 3'h0;
			track_ff <= 1'b1;
		end else begin
			if (REG_WR && REG_ADDR == shcc_pkg::REG_DATA)
				data_ff <= REG_WDATA[13:0];
			if (REG_WR && REG_ADDR == shcc_pkg::REG_CTRL) begin
				ctrl_ff <= REG_WDATA[1:0];
				if (REG_WDATA[shcc_pkg::CTRL_RST])
					rstp_ff <= 3'(shcc_pkg::RST_PULSE_CYC);
			end else if (rstp_ff != 3'h0) begin
				rstp_ff <= rstp_ff - 3'h1;
			end
			track_ff <= (REG_WR && REG_ADDR == shcc_pkg::REG_CTRL)
				? (REG_WDATA[shcc_pkg::CTRL_TRACK] && !REG_WDATA[shcc_pkg::CTRL_RST])
				: (ctrl_ff[shcc_pkg::CTRL_TRACK] && rstp_ff <= 3'h1);
		end
	end
	// ==========================================
	// register read port and pin outputs
	logic [31:0] rdata_ff;
	// the whole ten-bit header so all six address bits reach the parallel pins
	logic [9:0] par_ff;
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_ff <= 32'h00000000;
			par_ff <= 10'h000;
		end else begin
			par_ff <= word_ff[23:14];
			rdata_ff <= 32'h00000000;
			if (REG_RD) begin
				unique case (REG_ADDR)
					shcc_pkg::REG_DATA: rdata_ff <= {18'h00000, data_ff};
					shcc_pkg::REG_CTRL: rdata_ff <= {30'h00000000, ctrl_ff};
					shcc_pkg::REG_STAT: rdata_ff <= {29'h00000000, rbv_ff, !s2_ff[0],
						st_ff != H_IDLE};
					shcc_pkg::REG_RB: rdata_ff <= {18'h00000, rb_ff};
					default: rdata_ff <= 32'h00000000;
				endcase
			end
		end
	end
	assign REG_RDATA = rdata_ff;
	assign LINK.port_select = ctrl_ff[shcc_pkg::CTRL_SER];
	assign LINK.cs_sync_n = cs_n_ff;
	assign LINK.wr_n = wr_n_ff;
	assign LINK.sclk = sclk_ff;
	assign LINK.sdin = sdin_ff;
	assign LINK.cal = par_ff[shcc_pkg::HDR_CAL];
	assign LINK.offset_sel = par_ff[shcc_pkg::HDR_OFFS];
	assign LINK.channel_address = par_ff[5:0];
	assign LINK.track_rst_n = track_ff;
endmodule : shcc_host

// ==== testbench/shcc_link_monitor.sv ====
// wire-level checker for the sample-hold link between host and device
// assumes both ends share CORE_CLK and ARST_N with this checker
`timescale 1ns/1ps
module shcc_link_monitor (
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	input wire logic port_select,
	input wire logic cs_sync_n,
	input wire logic wr_n,
	input wire logic sclk,
	input wire logic sdin,
	input wire logic sdout,
	input wire logic busy_n,
	input wire logic track_rst_n
);
	localparam int ACQ_MAX = 640;
	logic sclk_ff;
	logic cs_ff;
	logic pend_ff;
	logic rbfr_ff;
	logic [4:0] nbit_ff;
	logic [1:0] mode_ff;
	logic [9:0] busy_cnt_ff;
	wire sfall = sclk_ff && !sclk;
	// readback frames carry no header, so they are kept out of the decode
	wire hdr = sfall && !cs_sync_n && port_select && nbit_ff == 5'h9 && !rbfr_ff;
	// ==========================================
	// frame tracking
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sclk_ff <= 1'b1;
			cs_ff <= 1'b1;
			pend_ff <= 1'b0;
			rbfr_ff <= 1'b0;
			nbit_ff <= 5'h0;
			mode_ff <= 2'h0;
		end else begin
			sclk_ff <= sclk;
			cs_ff <= cs_sync_n;
			if (cs_sync_n) nbit_ff <= 5'h0;
			else if (sfall && nbit_ff != 5'h1f) nbit_ff <= nbit_ff + 5'h1;
			if (sfall && !cs_sync_n && nbit_ff < 5'h2) mode_ff <= {mode_ff[0], sdin};
			if (cs_ff && !cs_sync_n) begin
				rbfr_ff <= pend_ff;
				pend_ff <= 1'b0;
			end else if (hdr && mode_ff[1]) begin
				pend_ff <= 1'b1;
			end
		end
	end
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) busy_cnt_ff <= 10'h0;
		else busy_cnt_ff <= busy_n ? 10'h0 : busy_cnt_ff + 10'h1;
	end
	// ==========================================
	// assertions
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	sequence hdr_s(logic [1:0] m);
		hdr && mode_ff == m;
	endsequence
	sha_start_a: assert property (hdr_s(2'h0) ##0 (track_rst_n && busy_n) |-> ##[1:8] !busy_n)
		else $error("no acquisition after sample-hold header");
	dac_quiet_a: assert property (hdr_s(2'h1) |=> busy_n [*8])
		else $error("dac write started an acquisition");
	rb_quiet_a: assert property (hdr_s(2'h3) |=> busy_n [*8])
		else $error("readback-only started an acquisition");
	par_start_a: assert property ($rose(wr_n) && !cs_sync_n && !port_select && track_rst_n
		&& busy_n |-> ##[1:8] !busy_n)
		else $error("no acquisition after parallel strobe");
	acq_len_a: assert property (busy_cnt_ff <= ACQ_MAX)
		else $error("acquisition longer than allowed");
	track_busy_a: assert property ($fell(busy_n) |-> track_rst_n)
		else $error("busy fell while track low");
	sdout_edge_a: assert property ($changed(sdout) && !cs_sync_n |-> sclk)
		else $error("readback data changed in low clock phase");
	sdout_idle_a: assert property (cs_sync_n [*8] |-> !sdout)
		else $error("readback data driven outside frame");
	sdin_hold_a: assert property ($fell(sclk) |-> $stable(sdin))
		else $error("serial data moved at falling clock");
	sclk_rate_a: assert property ($fell(sclk) |-> (!sclk) [*8])
		else $error("serial clock low phase too short");
endmodule : shcc_link_monitor

// ==== testbench/sample_hold_channel_control_test.sv ====
// self-checking bench: host and device joined by the link interface
// assumes host register map and timing of the design package
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module sample_hold_channel_control_test;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [13:0] adc_code = 14'h0;
	logic [6:0] dac_rd_addr = 7'h0;
	logic dac_en = 1'b0;
	logic [13:0] dac_rd_data;
	logic [64:0] route_vin;
	logic [13:0] offset_channel_output;
	logic rd_q = 1'b0;
	logic dac_q = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] ev;
	logic [31:0] seed_v;
	logic [13:0] code;
	logic [13:0] offs_code;
	logic [5:0] ch;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	shcc_if link();
	shcc_dev u_shcc_dev (.CORE_CLK(core_clk), .ARST_N(arst_n), .LINK(link.dev),
		.ADC_CODE(adc_code), .DAC_RD_ADDR(dac_rd_addr), .DAC_RD_DATA(dac_rd_data),
		.ROUTE_VIN(route_vin), .OFFSET_CHANNEL_OUTPUT(offset_channel_output));
	shcc_host u_shcc_host (.CORE_CLK(core_clk), .ARST_N(arst_n), .LINK(link.host),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata));
	shcc_link_monitor u_mon (.CORE_CLK(core_clk), .ARST_N(arst_n),
		.port_select(link.port_select), .cs_sync_n(link.cs_sync_n), .wr_n(link.wr_n),
		.sclk(link.sclk), .sdin(link.sdin), .sdout(link.sdout), .busy_n(link.busy_n),
		.track_rst_n(link.track_rst_n));
	always #12.5 core_clk = ~core_clk;
	// ==========================================
	// result watcher: oldest note against each answer
	always @(posedge core_clk) begin
		if (rd_q || dac_q) begin
			ev = (exp_q.size() != 0) ? exp_q.pop_front() : 32'hffffffff;
			`CHK(rd_q ? reg_rdata : {18'h0, dac_rd_data}, ev)
		end
		rd_q <= reg_rd;
		dac_q <= dac_en;
	end
	// cut a hang short; the whole run needs well under this
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			$display("[FAIL] %0t run did not finish", $time);
			end_of_test();
		end
	end
	// ==========================================
	// bus tasks
	task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : reg_wr_t
	task automatic reg_rd_t(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask : reg_rd_t
	task automatic dac_rd_t(input logic [6:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		dac_rd_addr <= a;
		dac_en <= 1'b1;
		@(posedge core_clk);
		dac_en <= 1'b0;
	endtask : dac_rd_t
	// idle means no frame, no strobe and no acquisition for a while
	task automatic wait_idle;
		int q;
		q = 0;
		repeat (20) @(posedge core_clk);
		while (q < 24) begin
			@(posedge core_clk);
			q = (link.busy_n && link.cs_sync_n && link.wr_n) ? q + 1 : 0;
		end
	endtask : wait_idle
	task automatic cmd(input logic [1:0] m, input logic c, input logic o, input logic [5:0] a);
		reg_wr_t(shcc_pkg::REG_CMD, {22'h0, m, c, o, a});
		wait_idle();
	endtask : cmd
	task automatic acq(input logic [1:0] m, input logic c, input logic [5:0] a, input logic trk);
		adc_code <= 14'($urandom);
		if (trk) reg_wr_t(shcc_pkg::REG_CTRL, 32'h2);
		reg_wr_t(shcc_pkg::REG_CMD, {22'h0, m, c, 1'b0, a});
		if (trk) begin
			repeat (300) @(posedge core_clk);
			`CHK(link.busy_n, 1'b1)
			`CHK(route_vin[a], 1'b1)
			reg_wr_t(shcc_pkg::REG_CTRL, 32'h3);
		end
		for (int k = 0; k < 400 && link.busy_n; k++) @(posedge core_clk);
		`CHK(route_vin[a], 1'b1)
		wait_idle();
		`CHK(route_vin, 65'h0)
		dac_rd_t({1'b0, a}, {18'h0, adc_code});
	endtask : acq
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// ==========================================
	// main sequence
	initial begin
		seed_v = $urandom(32'h35b4eff6);
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 66; i++) dac_rd_t(7'(i), 32'h0);
		reg_rd_t(shcc_pkg::REG_STAT, 32'h0);
		reg_rd_t(8'h1c, 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			code = 14'($urandom);
			ch = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
			if (i == 3) offs_code = code;
			reg_wr_t(shcc_pkg::REG_DATA, {18'h0, code});
			cmd(shcc_pkg::MODE_DAC, 1'b0, i == 3, ch);
			dac_rd_t((i == 3) ? 7'h40 : {1'b0, ch}, {18'h0, code});
			if (i == 3) `CHK(offset_channel_output, code)
			cmd(shcc_pkg::MODE_RB, 1'b0, i == 3, ch);
			reg_wr_t(shcc_pkg::REG_RBGO, 32'h0);
			wait_idle();
			reg_rd_t(shcc_pkg::REG_RB, {18'h0, code});
			reg_rd_t(shcc_pkg::REG_STAT, 32'h4);
		end
		$display("test dac write and readback done");
		acq(shcc_pkg::MODE_SHA, 1'b0, 6'h15, 1'b0);
		acq(shcc_pkg::MODE_SHA, 1'b1, 6'h07, 1'b0);
		dac_rd_t(7'h00, {18'h0, adc_code});
		dac_rd_t(7'h3f, {18'h0, adc_code});
		dac_rd_t(7'h40, {18'h0, offs_code});
		$display("test acquisitions done");
		acq(shcc_pkg::MODE_ACQ_RB, 1'b0, 6'h2a, 1'b0);
		reg_wr_t(shcc_pkg::REG_RBGO, 32'h0);
		wait_idle();
		reg_rd_t(shcc_pkg::REG_RB, {18'h0, adc_code});
		$display("test acquire readback done");
		acq(shcc_pkg::MODE_SHA, 1'b0, 6'h31, 1'b1);
		$display("test track done");
		reg_wr_t(shcc_pkg::REG_CTRL, 32'h1);
		acq(shcc_pkg::MODE_SHA, 1'b0, 6'h2d, 1'b0);
		reg_wr_t(shcc_pkg::REG_CTRL, 32'h3);
		$display("test parallel done");
		reg_wr_t(shcc_pkg::REG_CTRL, 32'h7);
		wait_idle();
		dac_rd_t(7'h2d, 32'h0);
		dac_rd_t(7'h40, 32'h0);
		`CHK(offset_channel_output, 14'h0)
		$display("test soft reset done");
		repeat (4) @(posedge core_clk);
		end_of_test();
	end
endmodule : sample_hold_channel_control_test
